// *** itsf_pkg.sv ***
/*
  Package for the input and temperature status flag bank: command codes,
  bit positions, reset values and supported-bit masks.
  Assumes a byte-wide command/data port from the serial bus front end.
*/
`default_nettype none
package itsf_pkg;
  // ==========================================================
  // Command codes
  localparam logic [7:0] ITSF_CMD_INPUT_STATUS = 8'h7c;
  localparam logic [7:0] ITSF_CMD_TEMP_STATUS = 8'h7d;
  localparam logic [7:0] ITSF_CMD_GLOBAL_FAULT_CLEAR_COMMAND = 8'h03;
  // ==========================================================
  // Bit positions
  localparam int ITSF_BIT_IN_OVF = 7;
  localparam int ITSF_BIT_IN_UV = 3;
  localparam int ITSF_BIT_OT_FAULT = 7;
  localparam int ITSF_BIT_OT_WARN = 6;
  // ==========================================================
  // Reset values and supported masks
  localparam logic [7:0] ITSF_INPUT_RESET = 8'h00;
  localparam logic [7:0] ITSF_TEMP_RESET = 8'h00;
  localparam logic [7:0] ITSF_INPUT_MASK = 8'h88;
  localparam logic [7:0] ITSF_TEMP_MASK = 8'hc0;
  // ==========================================================
  // Fault disable bit order
  localparam int ITSF_DIS_IN_OVF = 0;
  localparam int ITSF_DIS_IN_UV = 1;
  localparam int ITSF_DIS_OT_FAULT = 2;
  localparam int ITSF_DIS_OT_WARN = 3;
endpackage : itsf_pkg
`default_nettype wire

// *** itsf_uv_arm.sv ***
/*
  Arms low-input-voltage reporting once the input has first risen above
  the turn-on threshold. Assumes the threshold compare is synchronous.
*/
`default_nettype none
module itsf_uv_arm (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_above_on,
  output logic o_armed
);
  logic armed_q;
  logic armed_d;

  always_comb begin
    armed_d = armed_q | i_above_on;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
    end
  end

  assign o_armed = armed_q;
endmodule : itsf_uv_arm
`default_nettype wire

// *** itsf_status_bank.sv ***
/*
  Input and temperature latched status flags with write-1-to-clear byte
  access, global clear, clear on output turn-on and per-event disables.
  Assumes detectors, thresholds and alert pin logic sit outside; event
  inputs come from logic on the same clock and need no synchroniser.
*/
// Overview of operation
// - Supported flags stay set after their condition goes away; the low-input flag clears above turn-on.
// - Global global_fault_clear_command command clears all supported flags.
// - Output turn-on clears all supported flags.
// - Byte write clears exactly the flags written with 1b.
// - Alert mask configuration never affects flag setting.
// - Disabled events neither set a flag nor raise alert.
// - Input bit 7 latches input overvoltage fault; resets to 0.
// - Low-input flag ignored until input first exceeds turn-on threshold.
// - After arming, each drop below turn-off threshold latches flag and alerts.
// - Low-input flag 0b above turn-on, 1b below turn-off.
// - Temperature bit 7 latches overtemperature fault; resets to 0.
// - Temperature bit 6 latches overtemperature warning; resets to 0.
// - Unsupported bits read 0 and ignore writes.
// - Input status answers 7Ch, temperature 7Dh, byte read and write.
`default_nettype none
module itsf_status_bank
  import itsf_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_wr_stb,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_stb,
  input wire logic i_output_turn_on,
  input wire logic [3:0] i_fault_disable,
  input wire logic i_in_ovf_event,
  input wire logic i_in_above_on,
  input wire logic i_in_below_off,
  input wire logic i_ot_fault_event,
  input wire logic i_ot_warn_event,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_cmd_hit,
  output logic o_uv_alert
);
  // ==========================================================
  // State
  logic [7:0] in_q;
  logic [7:0] in_d;
  logic [7:0] tmp_q;
  logic [7:0] tmp_d;
  logic [7:0] rd_q;
  logic [7:0] rd_d;
  logic rv_q;
  logic rv_d;
  logic hit_q;
  logic hit_d;
  logic al_q;
  logic al_d;
  logic armed;
  logic below_q;
  logic below_d;
  logic uv_evt;
  logic [7:0] in_set;
  logic [7:0] tmp_set;
  logic [7:0] in_clr;
  logic [7:0] tmp_clr;
  logic clr_all;

  // Arming, like the below-turn-off edge register, is state that no flag clear touches
  itsf_uv_arm u_arm (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_above_on(i_in_above_on),
    .o_armed(armed)
  );

  // Sticky set wins over any clear in the same cycle
  function automatic logic [7:0] w1c_next(input logic [7:0] cur, input logic [7:0] set,
                                          input logic [7:0] clr, input logic [7:0] msk);
    w1c_next = ((cur & ~clr) | set) & msk;
  endfunction : w1c_next

  // ==========================================================
  // Next state
  always_comb begin
    // Edge of the below-turn-off level so each new drop latches
    uv_evt = i_in_below_off & ~below_q & armed & ~i_fault_disable[ITSF_DIS_IN_UV];
    clr_all = (i_wr_stb & (i_cmd_code == ITSF_CMD_GLOBAL_FAULT_CLEAR_COMMAND)) | i_output_turn_on;
    in_set = 8'h00;
    in_set[ITSF_BIT_IN_OVF] = i_in_ovf_event & ~i_fault_disable[ITSF_DIS_IN_OVF];
    in_set[ITSF_BIT_IN_UV] = uv_evt;
    tmp_set = 8'h00;
    tmp_set[ITSF_BIT_OT_FAULT] = i_ot_fault_event & ~i_fault_disable[ITSF_DIS_OT_FAULT];
    tmp_set[ITSF_BIT_OT_WARN] = i_ot_warn_event & ~i_fault_disable[ITSF_DIS_OT_WARN];
    in_clr = {8{clr_all}};
    tmp_clr = {8{clr_all}};
    if (i_wr_stb && i_cmd_code == ITSF_CMD_INPUT_STATUS) begin
      in_clr = in_clr | i_wr_data;
    end
    if (i_wr_stb && i_cmd_code == ITSF_CMD_TEMP_STATUS) begin
      tmp_clr = tmp_clr | i_wr_data;
    end
    // Above turn-on the low-input flag reads 0; a fresh drop still sets it
    in_clr[ITSF_BIT_IN_UV] = in_clr[ITSF_BIT_IN_UV] | i_in_above_on;
    in_d = w1c_next(in_q, in_set, in_clr, ITSF_INPUT_MASK);
    tmp_d = w1c_next(tmp_q, tmp_set, tmp_clr, ITSF_TEMP_MASK);
    rd_d = rd_q;
    rv_d = 1'b0;
    hit_d = 1'b0;
    if (i_rd_stb) begin
      rv_d = 1'b1;
      case (i_cmd_code)
        ITSF_CMD_INPUT_STATUS: begin
          rd_d = in_q;
          hit_d = 1'b1;
        end
        ITSF_CMD_TEMP_STATUS: begin
          rd_d = tmp_q;
          hit_d = 1'b1;
        end
        default: begin
          // Unknown codes answer 00 rather than stale flags
          rd_d = 8'h00;
        end
      endcase
    end
    al_d = uv_evt;
    // Low after reset; arming is low then too, so no false edge can alert
    below_d = i_in_below_off;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      in_q <= ITSF_INPUT_RESET;
      tmp_q <= ITSF_TEMP_RESET;
      rd_q <= 8'h00;
      rv_q <= 1'b0;
      hit_q <= 1'b0;
      al_q <= 1'b0;
      below_q <= 1'b0;
    end else begin
      in_q <= in_d;
      tmp_q <= tmp_d;
      rd_q <= rd_d;
      rv_q <= rv_d;
      hit_q <= hit_d;
      al_q <= al_d;
      below_q <= below_d;
    end
  end

  assign o_rd_data = rd_q;
  assign o_rd_valid = rv_q;
  assign o_cmd_hit = hit_q;
  assign o_uv_alert = al_q;

  // ==========================================================
  // Checks
  // Flag behaviour
  a_flag_sticky: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (in_q[ITSF_BIT_IN_OVF] && !clr_all && !(i_wr_stb && i_cmd_code == ITSF_CMD_INPUT_STATUS))
    |=> in_q[ITSF_BIT_IN_OVF]) else $error("overvoltage flag dropped");
  a_ot_sticky: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (tmp_q[ITSF_BIT_OT_FAULT] && !clr_all && !(i_wr_stb && i_cmd_code == ITSF_CMD_TEMP_STATUS))
    |=> tmp_q[ITSF_BIT_OT_FAULT]) else $error("overtemp flag dropped");
  a_clear_all: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (clr_all && !i_in_ovf_event && !i_ot_fault_event && !i_ot_warn_event && !uv_evt)
    |=> (in_q == 8'h00 && tmp_q == 8'h00)) else $error("clear all failed");
  a_turn_on_clr: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_output_turn_on && !i_ot_warn_event) |=> !tmp_q[ITSF_BIT_OT_WARN])
    else $error("turn-on did not clear");
  a_w1c_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_wr_stb && i_cmd_code == ITSF_CMD_TEMP_STATUS && !i_wr_data[ITSF_BIT_OT_FAULT]
     && !i_output_turn_on && tmp_q[ITSF_BIT_OT_FAULT]) |=> tmp_q[ITSF_BIT_OT_FAULT])
    else $error("write zero cleared flag");
  a_w1c_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_wr_stb && i_cmd_code == ITSF_CMD_INPUT_STATUS && i_wr_data[ITSF_BIT_IN_OVF]
     && !i_in_ovf_event) |=> !in_q[ITSF_BIT_IN_OVF]) else $error("write one kept flag");
  a_disable_blk: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!in_q[ITSF_BIT_IN_OVF] && i_fault_disable[ITSF_DIS_IN_OVF]) |=> !in_q[ITSF_BIT_IN_OVF])
    else $error("disabled event set flag");
  a_uv_disabled: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!in_q[ITSF_BIT_IN_UV] && i_fault_disable[ITSF_DIS_IN_UV])
    |=> (!in_q[ITSF_BIT_IN_UV] && !o_uv_alert)) else $error("disabled low input set flag");
  a_ovf_latch: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_in_ovf_event && !i_fault_disable[ITSF_DIS_IN_OVF]) |=> in_q[ITSF_BIT_IN_OVF])
    else $error("overvoltage not latched");
  a_uv_unarmed: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!armed && !in_q[ITSF_BIT_IN_UV]) |=> (!in_q[ITSF_BIT_IN_UV] && !o_uv_alert))
    else $error("undervoltage before arming");
  a_uv_alert: assert property (@(posedge i_core_clk) disable iff (i_rst)
    uv_evt |=> (o_uv_alert && in_q[ITSF_BIT_IN_UV])) else $error("undervoltage not alerted");
  a_alert_pulse: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_uv_alert |=> !o_uv_alert)
    else $error("alert longer than one cycle");
  a_above_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_in_above_on && !uv_evt) |=> !in_q[ITSF_BIT_IN_UV])
    else $error("low input flag kept above turn-on");
  a_ot_latch: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ot_fault_event && !i_fault_disable[ITSF_DIS_OT_FAULT]) |=> tmp_q[ITSF_BIT_OT_FAULT])
    else $error("overtemp fault not latched");
  a_warn_latch: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ot_warn_event && !i_fault_disable[ITSF_DIS_OT_WARN]) |=> tmp_q[ITSF_BIT_OT_WARN])
    else $error("overtemp warning not latched");
  a_unused_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ((in_q & ~ITSF_INPUT_MASK) == 8'h00 && (tmp_q & ~ITSF_TEMP_MASK) == 8'h00))
    else $error("unsupported bit set");
  // Read path: valid and hit are single pulses, data holds until the next read
  a_read_data: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_rd_stb && i_cmd_code == ITSF_CMD_TEMP_STATUS) |=> (o_rd_valid && o_cmd_hit
     && o_rd_data == $past(tmp_q))) else $error("read data wrong");
  a_input_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_rd_stb && i_cmd_code == ITSF_CMD_INPUT_STATUS) |=> (o_rd_valid && o_cmd_hit
     && o_rd_data == $past(in_q))) else $error("input read data wrong");
  a_unknown_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_rd_stb && i_cmd_code != ITSF_CMD_INPUT_STATUS && i_cmd_code != ITSF_CMD_TEMP_STATUS)
    |=> (o_rd_valid && !o_cmd_hit && o_rd_data == 8'h00))
    else $error("unknown code answered");
  a_rd_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_rd_stb |=> (!o_rd_valid && $stable(o_rd_data)))
    else $error("read data not held");
endmodule : itsf_status_bank
`default_nettype wire

// *** itsf_host_model.sv ***
/*
  Host model for the status bank: issues random byte reads, byte writes,
  global clears and output turn-on pulses, at most one read or write per cycle; turn-on is drawn separately.
  Assumes the bench seeds $urandom once before the first request.
*/
`default_nettype none
module itsf_host_model (
  input wire logic i_core_clk,
  input wire logic i_rst,
  output logic [7:0] o_cmd_code,
  output logic o_wr_stb,
  output logic [7:0] o_wr_data,
  output logic o_rd_stb,
  output logic o_output_turn_on
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] codes [4] = '{8'h7c, 8'h7d, 8'h03, 8'h5a};
  int op;
  initial begin
    o_cmd_code = 8'h00;
    o_wr_stb = 1'b0;
    o_wr_data = 8'h00;
    o_rd_stb = 1'b0;
    o_output_turn_on = 1'b0;
  end
  // ==========================================
  // Requests
  // Strobes last one cycle; no request is issued on an edge that sees reset high
  always @(posedge i_core_clk) begin
    op = $urandom_range(3);
    o_cmd_code <= codes[$urandom_range(3)];
    o_wr_stb <= !i_rst && op == 1;
    o_rd_stb <= !i_rst && op >= 2;
    o_wr_data <= 8'($urandom);
    o_output_turn_on <= !i_rst && $urandom_range(15) == 0;
  end
endmodule : itsf_host_model
`default_nettype wire

// *** itsf_status_bank_tb_top.sv ***
/*
  Bench for the status bank: random host traffic and random fault events,
  checked against a cycle model at every output.
  Assumes above-on and below-off levels are never high together.
*/
`default_nettype none
module itsf_status_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import itsf_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ovf = 1'b0, otf = 1'b0, otw = 1'b0;
  logic above = 1'b0, below = 1'b0, wr, rd, ton, vld, hit, alr;
  logic [3:0] dis = 4'h0;
  logic [7:0] code, wd, rdat, fin, ftp, cin, ctp, m_rd;
  logic armed, pb, uvset, m_vld, m_hit, m_alert, seen_rst = 1'b0;
  int n_mismatch = 0, num_checks = 0, lvl = 2;
  itsf_host_model i_itsf_host_model (.i_core_clk(clk), .i_rst(rst), .o_cmd_code(code),
    .o_wr_stb(wr), .o_wr_data(wd), .o_rd_stb(rd), .o_output_turn_on(ton));
  itsf_status_bank i_itsf_status_bank (.i_core_clk(clk), .i_rst(rst), .i_cmd_code(code),
    .i_wr_stb(wr), .i_wr_data(wd), .i_rd_stb(rd), .i_output_turn_on(ton),
    .i_fault_disable(dis), .i_in_ovf_event(ovf), .i_in_above_on(above),
    .i_in_below_off(below), .i_ot_fault_event(otf), .i_ot_warn_event(otw),
    .o_rd_data(rdat), .o_rd_valid(vld), .o_cmd_hit(hit), .o_uv_alert(alr));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic close_out();
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // ==========================================
  // Events: rare pulses, slow input level walk
  always @(posedge clk) begin
    if ($urandom_range(7) == 0) lvl = $urandom_range(2);
    above <= lvl == 0;
    below <= lvl == 2;
    ovf <= $urandom_range(15) == 0;
    otf <= $urandom_range(15) == 0;
    otw <= $urandom_range(15) == 0;
    dis <= ($urandom_range(5) == 0) ? 4'($urandom) : 4'h0;
  end
  // ==========================================
  // Cycle model; reads pre-edge values, as the design does
  always @(posedge clk) begin
    if (seen_rst) begin
      chk("rd_valid", 8'(m_vld), 8'(vld));
      chk("cmd_hit", 8'(m_hit), 8'(hit));
      chk("uv_alert", 8'(m_alert), 8'(alr));
      chk("rd_data", m_rd, rdat);
    end
    seen_rst = seen_rst || rst;
    if (rst) begin
      {fin, ftp, m_rd, armed, pb, m_vld, m_hit, m_alert} = '0;
    end else begin
      m_vld = rd;
      m_hit = rd && (code == 8'h7c || code == 8'h7d);
      if (rd) m_rd = (code == 8'h7c) ? fin : (code == 8'h7d) ? ftp : 8'h00;
      cin = (wr && code == 8'h7c) ? wd : 8'h00;
      ctp = (wr && code == 8'h7d) ? wd : 8'h00;
      if (ton || (wr && code == 8'h03)) {cin, ctp} = 16'hffff;
      cin[3] = cin[3] | above;
      uvset = armed && below && !pb && !dis[1];
      m_alert = uvset;
      fin = ((fin & ~cin) | {ovf && !dis[0], 3'h0, uvset, 3'h0}) & 8'h88;
      ftp = ((ftp & ~ctp) | {otf && !dis[2], otw && !dis[3], 6'h00}) & 8'hc0;
      armed = armed || above;
      pb = below;
    end
  end
  initial begin
    void'($urandom(32'h6615));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (1500) @(posedge clk);
    // Mid-run reset: flags, arming and read data must all restart
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (1500) @(posedge clk);
    close_out();
  end
  initial begin
    #(4000 * 50);
    n_mismatch++;
    close_out();
  end
endmodule : itsf_status_bank_tb_top
`default_nettype wire
